/* File: pmc_params.svh */
// Purpose: Register map, field layout and timing constants of the
//          proximity measurement and calibration block.
// Assumes: 100 MHz system clock.
// Notes:   Definitions only; included by bare name.
// Operation
// - Resolution code picks bits and conversion time.
// - Current code picks LED peak drive.
// - Pulse bit picks 16 or 32 pulses.
// - Far threshold held at 88H/89H.
// - Near threshold held at 8AH/8BH.
// - Crosstalk offset at 8CH/8DH is subtracted.
// - Signed offset at 8EH, 16 counts/step.
// - Bit 7 sign: 0 subtracts, 1 adds.
// - Result at 90H/91H is raw minus crosstalk, with the signed and calibration offsets applied.
// - Above near is near; below far is not.
// - Integrator saturation sets flag at 91H.
// - Seven-bit read-only calibration outcome at C0H.
// - Calibration runs only when C1H enable set.
// - Target code picks 0 or 2^(n+4)-1 counts.
// - Search-enable bit at C2H applies results.
// - Reset loads every register default.
// - Auto-shutdown after one measurement.
// - Each LED pulse lasts 6.5 us.
// - Near only after consecutive exceedances.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PMC_A_RES      8'h85
`define PMC_A_LED      8'h86
`define PMC_A_FAR_LO   8'h88
`define PMC_A_FAR_HI   8'h89
`define PMC_A_NEAR_LO  8'h8A
`define PMC_A_NEAR_HI  8'h8B
`define PMC_A_XT_LO    8'h8C
`define PMC_A_XT_HI    8'h8D
`define PMC_A_SOFS     8'h8E
`define PMC_A_RSLT_LO  8'h90
`define PMC_A_RSLT_HI  8'h91
`define PMC_A_CAL_OUT  8'hC0
`define PMC_A_CAL_EN   8'hC1
`define PMC_A_CAL_GOAL 8'hC2

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PMC_SUM_BIT    3
`define PMC_SRCH_BIT   3
`define PMC_SAT_BIT    7
`define PMC_SIGN_BIT   7
`define PMC_RST_BYTE   8'h00

// ----------------------------------------------------------------------
// Timing and scaling
// ----------------------------------------------------------------------
`define PMC_CLK_NS     10
`define PMC_T14_NS     7600000
`define PMC_T12_NS     1900000
`define PMC_T10_NS     480000
`define PMC_T8_NS      120000
`define PMC_PULSE_NS   6500
`define PMC_STEP_CNT   16
`define PMC_PULSES_LO  6'h10
`define PMC_PULSES_HI  6'h20
`define PMC_MA_10      8'h0A
`define PMC_MA_82      8'h52
`define PMC_MA_155     8'h9B
`define PMC_MA_210     8'hD2

`endif

/* File: pmc_pkg.sv */
// Purpose: Types shared by the proximity measurement block.
// Assumes: Nothing beyond the parameter header.
// Notes:   No imports; users write pmc_pkg::name.
`default_nettype none
package pmc_pkg;
	typedef enum logic [1:0] {
		PMC_IDLE,
		PMC_PULSE,
		PMC_SETTLE,
		PMC_UPDATE
	} pmc_state_t;
endpackage
`default_nettype wire

/* File: pmc_led_pulser.sv */
// Purpose: Emitter pulse train for one proximity conversion.
// Assumes: start_in is a one-cycle pulse from the core.
// Notes:   Gap between pulses equals the pulse width.
`include "pmc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pmc_led_pulser #(
	parameter int unsigned PULSE_CYC = (`PMC_PULSE_NS + `PMC_CLK_NS - 1)
	                                   / `PMC_CLK_NS
) (
	// Clock and reset.
	input  wire logic       clk_sys_in,
	input  wire logic       sys_rst_in,
	// Control.
	input  wire logic       start_in,
	input  wire logic [5:0] pulses_in,
	// Outputs.
	output logic            led_on_out,
	output logic            done_out
);
	if (PULSE_CYC < 1 || PULSE_CYC > 4095)
	begin : g_bad
		$error("PULSE_CYC out of range");
	end

	logic [11:0] ph_q;
	logic [5:0]  left_q;
	logic        on_q;
	logic        act_q;

	// Alternate on and off phases until the pulse count runs out.
	always_ff @(posedge clk_sys_in)
	begin
		done_out <= 1'b0;
		if (sys_rst_in)
		begin
			ph_q <= 12'h000;
			left_q <= 6'h00;
			on_q <= 1'b0;
			act_q <= 1'b0;
		end
		else if (start_in)
		begin
			ph_q <= 12'h000;
			left_q <= pulses_in;
			on_q <= 1'b1;
			act_q <= 1'b1;
		end
		else if (act_q)
		begin
			if (ph_q == 12'(PULSE_CYC - 1))
			begin
				ph_q <= 12'h000;
				if (on_q)
				begin
					on_q <= 1'b0;
					left_q <= left_q - 6'h01;
				end
				else if (left_q == 6'h00)
				begin
					act_q <= 1'b0;
					done_out <= 1'b1;
				end
				else
					on_q <= 1'b1;
			end
			else
				ph_q <= ph_q + 12'h001;
		end
	end

	assign led_on_out = on_q;

	// Helper: length of the current on phase and pulses seen.
	logic [11:0] run_q;
	logic [5:0]  seen_q;
	logic [5:0]  want_q;
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in || start_in)
		begin
			run_q <= 12'h000;
			seen_q <= 6'h00;
			want_q <= start_in ? pulses_in : 6'h00;
		end
		else
		begin
			run_q <= on_q ? run_q + 12'h001 : 12'h000;
			if (on_q && run_q == 12'h000)
				seen_q <= seen_q + 6'h01;
		end
	end

	sequence s_fall;
		on_q ##1 !on_q;
	endsequence
	property p_pulse_len;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_fall |-> $past(run_q) == 12'(PULSE_CYC - 1);
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("LED pulse width wrong");
	property p_pulse_cnt;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		done_out |-> seen_q == want_q;
	endproperty
	a_pulse_cnt: assert property (p_pulse_cnt)
		else $error("LED pulse count wrong");
endmodule
`default_nettype wire

/* File: pmc_core.sv */
// Purpose: Proximity conversion, offsets, near/far judgement and
//          calibration search behind the byte register port.
// Assumes: Register port is on clk_sys_in; detector pin is async.
// Notes:   Long conversion times are parameters for short sims.
`include "pmc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pmc_core #(
	parameter int unsigned T14_CYC = `PMC_T14_NS / `PMC_CLK_NS,
	parameter int unsigned T12_CYC = `PMC_T12_NS / `PMC_CLK_NS,
	parameter int unsigned T10_CYC = `PMC_T10_NS / `PMC_CLK_NS,
	parameter int unsigned T8_CYC  = `PMC_T8_NS / `PMC_CLK_NS
) (
	// Clock and reset.
	input  wire logic       clk_sys_in,
	input  wire logic       sys_rst_in,
	// Byte register port.
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	// Operating control from neighbouring logic.
	input  wire logic       meas_start_in,
	input  wire logic       auto_shutdown_in,
	input  wire logic [2:0] persistence_count_in,
	// Photodetector comparator pin.
	input  wire logic       afe_detect_in,
	// Emitter drive and status.
	output logic            led_on_out,
	output logic      [7:0] led_peak_current_out,
	output logic            meas_busy_out,
	output logic            meas_done_out,
	output logic            shutdown_out,
	output logic            near_out
);
	if (T8_CYC < 1 || T12_CYC < T10_CYC || T14_CYC >= 2 ** 20)
	begin : g_bad
		$error("Conversion time parameters out of range");
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	logic [1:0]  prox_resolution_q;
	logic [2:0]  led_cur_q;
	logic        sum_q;
	logic [13:0] far_threshold_q;
	logic [13:0] near_threshold_q;
	logic [13:0] crosstalk_offset_q;
	logic [7:0]  signed_count_offset_q;
	logic        calib_enable_q;
	logic [2:0]  target_q;
	logic        search_en_q;

	// Host writes; every field takes its default on reset.
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			prox_resolution_q <= 2'(`PMC_RST_BYTE);
			led_cur_q <= 3'(`PMC_RST_BYTE);
			sum_q <= 1'b0;
			far_threshold_q <= 14'(`PMC_RST_BYTE);
			near_threshold_q <= 14'(`PMC_RST_BYTE);
			crosstalk_offset_q <= 14'(`PMC_RST_BYTE);
			signed_count_offset_q <= `PMC_RST_BYTE;
			calib_enable_q <= 1'b0;
			target_q <= 3'(`PMC_RST_BYTE);
			search_en_q <= 1'b0;
		end
		else if (reg_wr_in)
		begin
			// Low byte at the lower address, six bits above it.
			if (reg_addr_in == `PMC_A_RES)
				prox_resolution_q <= reg_wdata_in[1:0];
			else if (reg_addr_in == `PMC_A_LED)
			begin
				led_cur_q <= reg_wdata_in[2:0];
				sum_q <= reg_wdata_in[`PMC_SUM_BIT];
			end
			else if (reg_addr_in == `PMC_A_FAR_LO)
				far_threshold_q[7:0] <= reg_wdata_in;
			else if (reg_addr_in == `PMC_A_FAR_HI)
				far_threshold_q[13:8] <= reg_wdata_in[5:0];
			else if (reg_addr_in == `PMC_A_NEAR_LO)
				near_threshold_q[7:0] <= reg_wdata_in;
			else if (reg_addr_in == `PMC_A_NEAR_HI)
				near_threshold_q[13:8] <= reg_wdata_in[5:0];
			else if (reg_addr_in == `PMC_A_XT_LO)
				crosstalk_offset_q[7:0] <= reg_wdata_in;
			else if (reg_addr_in == `PMC_A_XT_HI)
				crosstalk_offset_q[13:8] <= reg_wdata_in[5:0];
			else if (reg_addr_in == `PMC_A_SOFS)
				signed_count_offset_q <= reg_wdata_in;
			else if (reg_addr_in == `PMC_A_CAL_EN)
				calib_enable_q <= reg_wdata_in[0];
			else if (reg_addr_in == `PMC_A_CAL_GOAL)
			begin
				target_q <= reg_wdata_in[2:0];
				search_en_q <= reg_wdata_in[`PMC_SRCH_BIT];
			end
		end
	end

	// ------------------------------------------------------------------
	// Detector synchroniser and emitter drive
	// ------------------------------------------------------------------
	logic det_m_q;
	logic det_s_q;
	always_ff @(posedge clk_sys_in)
	begin
		det_m_q <= afe_detect_in;
		det_s_q <= det_m_q;
	end

	// Peak current decode; unlisted codes give zero peak current, but codes 4 to 6 still pulse led_on_out.
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			led_peak_current_out <= 8'h00;
		else
			case (led_cur_q)
				3'h1:    led_peak_current_out <= `PMC_MA_10;
				3'h2:    led_peak_current_out <= `PMC_MA_82;
				3'h3:    led_peak_current_out <= `PMC_MA_155;
				3'h7:    led_peak_current_out <= `PMC_MA_210;
				default: led_peak_current_out <= 8'h00;
			endcase
	end

	pmc_pkg::pmc_state_t st_q;
	logic                pulse_go;
	logic                pulse_done;
	logic                led_raw;

	assign pulse_go = (st_q == pmc_pkg::PMC_IDLE) && meas_start_in;

	pmc_led_pulser u_pulser (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.start_in   (pulse_go),
		.pulses_in  (sum_q ? `PMC_PULSES_HI : `PMC_PULSES_LO),
		.led_on_out (led_raw),
		.done_out   (pulse_done)
	);
	// A zero current code must not light the emitter at all.
	assign led_on_out = led_raw && (led_cur_q != 3'h0);

	// ------------------------------------------------------------------
	// Conversion sequencing
	// ------------------------------------------------------------------
	logic [19:0] dur_sel;
	logic [13:0] max_cnt;
	logic [19:0] timer_q;
	logic [13:0] raw_q;
	logic        sat_run_q;

	// Resolution trades count range against conversion time.
	always_comb
	begin
		case (prox_resolution_q)
			2'h0:
			begin
				dur_sel = 20'(T14_CYC);
				max_cnt = 14'h3FFF;
			end
			2'h1:
			begin
				dur_sel = 20'(T12_CYC);
				max_cnt = 14'h0FFF;
			end
			2'h2:
			begin
				dur_sel = 20'(T10_CYC);
				max_cnt = 14'h03FF;
			end
			default:
			begin
				dur_sel = 20'(T8_CYC);
				max_cnt = 14'h00FF;
			end
		endcase
	end

	// Pulse phase, then hold until the conversion time has elapsed.
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			st_q <= pmc_pkg::PMC_IDLE;
			timer_q <= 20'h00000;
		end
		else
			case (st_q)
				pmc_pkg::PMC_IDLE:
				begin
					timer_q <= 20'h00000;
					if (meas_start_in)
						st_q <= pmc_pkg::PMC_PULSE;
				end
				pmc_pkg::PMC_PULSE:
				begin
					timer_q <= timer_q + 20'h00001;
					if (pulse_done)
						st_q <= pmc_pkg::PMC_SETTLE;
				end
				pmc_pkg::PMC_SETTLE:
				begin
					timer_q <= timer_q + 20'h00001;
					if (timer_q >= dur_sel - 20'h00001)
						st_q <= pmc_pkg::PMC_UPDATE;
				end
				default:
					st_q <= pmc_pkg::PMC_IDLE;
			endcase
	end

	// Integrator: counts lit cycles with light seen, clips at full scale.
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in || pulse_go)
		begin
			raw_q <= 14'h0000;
			sat_run_q <= 1'b0;
		end
		else if (st_q == pmc_pkg::PMC_PULSE && led_on_out && det_s_q)
		begin
			if (raw_q >= max_cnt)
				sat_run_q <= 1'b1;
			else
				raw_q <= raw_q + 14'h0001;
		end
	end

	// ------------------------------------------------------------------
	// Result arithmetic
	// ------------------------------------------------------------------
	logic signed [17:0] acc;
	logic        [13:0] result_d;
	logic        [6:0]  cal_q;
	logic        [13:0] goal;

	// Raw minus crosstalk, then the signed step offset and, when
	// search is applied, the calibration correction; clamped to range.
	always_comb
	begin
		acc = $signed({4'h0, raw_q}) - $signed({4'h0, crosstalk_offset_q});
		if (signed_count_offset_q[`PMC_SIGN_BIT])
			acc = acc + $signed({7'h00, signed_count_offset_q[6:0], 4'h0});
		else
			acc = acc - $signed({7'h00, signed_count_offset_q[6:0], 4'h0});
		if (search_en_q)
			acc = acc - $signed({7'h00, cal_q, 4'h0});
		if (acc < 0)
			result_d = 14'h0000;
		else if (acc > $signed({4'h0, 14'h3FFF}))
			result_d = 14'h3FFF;
		else
			result_d = acc[13:0];
	end

	// Target counts are one below a power of two, or zero. The shift
	// amount is widened first so that codes 4 to 7 do not wrap.
	assign goal = (target_q == 3'h0) ? 14'h0000
		: 14'((14'h0001 << ({1'b0, target_q} + 4'h4)) - 14'h0001);

	logic [13:0] result_q;
	logic        sat_q;
	logic [2:0]  streak_q;

	// Result, flag and judgement land together at the end of a conversion.
	always_ff @(posedge clk_sys_in)
	begin
		meas_done_out <= 1'b0;
		if (sys_rst_in)
		begin
			result_q <= 14'h0000;
			sat_q <= 1'b0;
			near_out <= 1'b0;
			streak_q <= 3'h0;
		end
		else if (st_q == pmc_pkg::PMC_UPDATE)
		begin
			meas_done_out <= 1'b1;
			result_q <= result_d;
			sat_q <= sat_run_q;
			if (!near_out ? result_d > near_threshold_q
			              : result_d < far_threshold_q)
			begin
				if (streak_q >= persistence_count_in)
				begin
					near_out <= !near_out;
					streak_q <= 3'h0;
				end
				else
					streak_q <= streak_q + 3'h1;
			end
			else
				streak_q <= 3'h0;
		end
	end

	// Calibration walks the correction toward the target count.
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			cal_q <= 7'h00;
		else if (st_q == pmc_pkg::PMC_UPDATE && calib_enable_q)
		begin
			if (result_d > goal && cal_q != 7'h7F)
				cal_q <= cal_q + 7'h01;
			else if (result_d < goal && cal_q != 7'h00)
				cal_q <= cal_q - 7'h01;
		end
	end

	// Auto-shutdown parks the block after one conversion until restarted.
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			shutdown_out <= 1'b0;
		else if (meas_start_in)
			shutdown_out <= 1'b0;
		else if (meas_done_out && auto_shutdown_in)
			shutdown_out <= 1'b1;
	end

	assign meas_busy_out = (st_q != pmc_pkg::PMC_IDLE) || shutdown_out;

	// ------------------------------------------------------------------
	// Register read-back
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
		begin
			if (reg_addr_in == `PMC_A_RES)
				reg_rdata_out <= {6'h00, prox_resolution_q};
			else if (reg_addr_in == `PMC_A_LED)
				reg_rdata_out <= {4'h0, sum_q, led_cur_q};
			else if (reg_addr_in == `PMC_A_FAR_LO)
				reg_rdata_out <= far_threshold_q[7:0];
			else if (reg_addr_in == `PMC_A_FAR_HI)
				reg_rdata_out <= {2'h0, far_threshold_q[13:8]};
			else if (reg_addr_in == `PMC_A_NEAR_LO)
				reg_rdata_out <= near_threshold_q[7:0];
			else if (reg_addr_in == `PMC_A_NEAR_HI)
				reg_rdata_out <= {2'h0, near_threshold_q[13:8]};
			else if (reg_addr_in == `PMC_A_XT_LO)
				reg_rdata_out <= crosstalk_offset_q[7:0];
			else if (reg_addr_in == `PMC_A_XT_HI)
				reg_rdata_out <= {2'h0, crosstalk_offset_q[13:8]};
			else if (reg_addr_in == `PMC_A_SOFS)
				reg_rdata_out <= signed_count_offset_q;
			else if (reg_addr_in == `PMC_A_RSLT_LO)
				reg_rdata_out <= result_q[7:0];
			else if (reg_addr_in == `PMC_A_RSLT_HI)
				reg_rdata_out <= {sat_q, 1'b0, result_q[13:8]};
			else if (reg_addr_in == `PMC_A_CAL_OUT)
				reg_rdata_out <= {1'b0, cal_q};
			else if (reg_addr_in == `PMC_A_CAL_EN)
				reg_rdata_out <= {7'h00, calib_enable_q};
			else if (reg_addr_in == `PMC_A_CAL_GOAL)
				reg_rdata_out <= {4'h0, search_en_q, target_q};
			else
				reg_rdata_out <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_update;
		st_q == pmc_pkg::PMC_UPDATE;
	endsequence
	property p_result;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_update and (signed_count_offset_q[6:0] == 7'h00) and !search_en_q
		and (raw_q >= crosstalk_offset_q)
		|=> result_q == $past(raw_q) - $past(crosstalk_offset_q);
	endproperty
	a_result: assert property (p_result)
		else $error("Result is not raw minus crosstalk");
	property p_sat;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_update and sat_run_q |=> sat_q ##1 !meas_done_out;
	endproperty
	a_sat: assert property (p_sat)
		else $error("Saturation flag not set");
	property p_near;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_update and !near_out and (result_d > near_threshold_q)
		and (streak_q >= persistence_count_in) |=> near_out;
	endproperty
	a_near: assert property (p_near)
		else $error("Near state not entered");
	property p_hold;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_update and !near_out and (result_d <= near_threshold_q)
		|=> !near_out && streak_q == 3'h0;
	endproperty
	a_hold: assert property (p_hold)
		else $error("Near state entered without exceedance");
	property p_cal;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		!calib_enable_q |=> $stable(cal_q);
	endproperty
	a_cal: assert property (p_cal)
		else $error("Calibration moved while disabled");
	property p_shut;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		s_update ##1 (auto_shutdown_in && !meas_start_in)
		|=> shutdown_out;
	endproperty
	a_shut: assert property (p_shut)
		else $error("No auto-shutdown after conversion");
	property p_dark;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		led_cur_q == 3'h0 |-> !led_on_out ##1 led_peak_current_out == 8'h00;
	endproperty
	a_dark: assert property (p_dark)
		else $error("Emitter driven with current code zero");
	property p_conv_len;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		$rose(st_q == pmc_pkg::PMC_UPDATE) |-> timer_q >= $past(dur_sel) - 20'h00001;
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("Conversion ended early");
endmodule
`default_nettype wire

/* File: pmc_optics_model.sv */
// Purpose: Optics in front of the detector: a reflector or empty space.
// Assumes: A present object keeps the comparator high throughout.
// Notes:   Skewed by 1 ns as the pin is asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module pmc_optics_model (
	// Scene control.
	input  wire logic object_in,
	// Comparator pin.
	output logic      detect_out
);
	// A strong reflector saturates the comparator, so the count is exact.
	assign #1 detect_out = object_in;
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench of the proximity measurement block.
// Assumes: Short conversion parameters; 100 MHz clock.
// Notes:   The bench plays the host on the byte strobe port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		checks++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("[ERR] %s exp %h got %h", nm, e, g); \
		end \
	end
module testbench;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic       clk_sys_in;
	logic       sys_rst_in;
	logic [7:0] addr, wdata, rdata, led_ma;
	logic       wr, rd, start, auto_sd, obj, det;
	logic [2:0] persist;
	logic       led_on, busy, done, sd, near;
	int         error_cnt = 0, checks = 0, cyc = 0, lit = 0, dones = 0;
	int         l0, d0;
	logic [7:0] map [15] = '{8'h85, 8'h86, 8'h88, 8'h89, 8'h8A, 8'h8B,
		8'h8C, 8'h8D, 8'h8E, 8'h90, 8'h91, 8'hC0, 8'hC1, 8'hC2, 8'hA5};
	logic [7:0] ma [8] = '{8'h00, 8'h0A, 8'h52, 8'h9B, 8'h00, 8'h00,
		8'h00, 8'hD2};
	// ------------------------------------------------------------------
	// Design and optics
	// ------------------------------------------------------------------
	pmc_core #(
		.T14_CYC(4000), .T12_CYC(2000), .T10_CYC(1000), .T8_CYC(500)
	) i_dut (
		.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .meas_start_in(start),
		.auto_shutdown_in(auto_sd), .persistence_count_in(persist),
		.afe_detect_in(det), .led_on_out(led_on),
		.led_peak_current_out(led_ma), .meas_busy_out(busy),
		.meas_done_out(done), .shutdown_out(sd), .near_out(near)
	);
	pmc_optics_model i_optics (.object_in(obj), .detect_out(det));
	// Free-running clock.
	initial
	begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// Counts lit cycles and done strobes; the ceiling catches a hang.
	always @(posedge clk_sys_in)
	begin
		cyc <= cyc + 1;
		if (led_on === 1'b1)
			lit <= lit + 1;
		if (done === 1'b1)
			dones <= dones + 1;
		if (cyc == 90000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	// ------------------------------------------------------------------
	// Host tasks
	// ------------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys_in);
		wr    <= 1'b0;
	endtask
	// Read data is registered, so it is taken after the strobe edge.
	task automatic chk_reg(input string nm, input logic [7:0] a,
		input logic [7:0] e);
		@(posedge clk_sys_in);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys_in);
		rd   <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask
	// One conversion, with a second start mid-run that must be ignored.
	task automatic convert();
		int n;
		l0 = lit;
		d0 = dones;
		@(posedge clk_sys_in);
		start <= 1'b1;
		@(posedge clk_sys_in);
		start <= 1'b0;
		repeat (100) @(posedge clk_sys_in);
		start <= 1'b1;
		@(posedge clk_sys_in);
		start <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		while (done !== 1'b1 && n < 30000);
		`CHK("done seen", 1'b1, done)
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		sys_rst_in = 1'b1;
		{addr, wdata, wr, rd, start, auto_sd, obj, persist} = '0;
		repeat (3) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_sys_in); // Settle before first access.
		// Defaults, then read-only and unmapped places ignore writes.
		foreach (map[i])
			chk_reg("reset value", map[i], 8'h00);
		foreach (map[i])
			wr_reg(map[i], 8'h2A);
		for (int i = 2; i < 9; i++)
			chk_reg("threshold rw", map[i], 8'h2A);
		for (int i = 9; i < 12; i++)
			chk_reg("read-only", map[i], 8'h00);
		chk_reg("unmapped", 8'hA5, 8'h00);
		$display("Test 1 done");
		for (int c = 0; c < 8; c++)
		begin
			wr_reg(8'h86, 8'(c));
			repeat (2) @(posedge clk_sys_in);
			#1;
			`CHK("led current", ma[c], led_ma)
		end
		$display("Test 2 done");
		// 14-bit, 16 pulses: 10400 - 100 + 2*16 = 0x285C, near.
		wr_reg(8'h85, 8'h00);
		wr_reg(8'h86, 8'h02);
		wr_reg(8'h89, 8'h08);
		wr_reg(8'h8A, 8'h00);
		wr_reg(8'h8B, 8'h10);
		wr_reg(8'h8C, 8'h64);
		wr_reg(8'h8D, 8'h00);
		wr_reg(8'h8E, 8'h82);
		wr_reg(8'h88, 8'h00);
		wr_reg(8'hC1, 8'h01);
		wr_reg(8'hC2, 8'h07);
		auto_sd <= 1'b1;
		obj     <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		convert();
		chk_reg("result lo", 8'h90, 8'h5C);
		chk_reg("result hi", 8'h91, 8'h28);
		chk_reg("cal outcome", 8'hC0, 8'h01);
		`CHK("lit cycles", 10400, lit - l0)
		`CHK("done count", 1, dones - d0)
		`CHK("near", 1'b1, near)
		`CHK("shutdown", 1'b1, sd)
		`CHK("busy", 1'b1, busy)
		$display("Test 3 done");
		// 8-bit clips at 255 with saturation; 255-100-32-16 = 0x6B.
		// Target 2047 lies above the result, so the outcome steps to 0.
		wr_reg(8'h85, 8'h03);
		wr_reg(8'h8E, 8'h02);
		wr_reg(8'hC2, 8'h0F);
		convert();
		chk_reg("result lo", 8'h90, 8'h6B);
		chk_reg("result hi", 8'h91, 8'h80);
		chk_reg("cal outcome", 8'hC0, 8'h00);
		`CHK("near", 1'b0, near)
		$display("Test 4 done");
		// Calibration off, one exceedance not enough: 0x281C, still far.
		wr_reg(8'h85, 8'h00);
		wr_reg(8'hC1, 8'h00);
		persist <= 3'h1;
		auto_sd <= 1'b0;
		convert();
		chk_reg("result lo", 8'h90, 8'h1C);
		chk_reg("result hi", 8'h91, 8'h28);
		chk_reg("cal outcome", 8'hC0, 8'h00);
		`CHK("near", 1'b0, near)
		`CHK("shutdown", 1'b0, sd)
		`CHK("busy", 1'b0, busy)
		$display("Test 5 done");
		repeat (4) @(posedge clk_sys_in); // Quiet before power-off.
		finish_test();
	end
endmodule
`default_nettype wire
